// ### design/itd_core.sv
`timescale 1ns/1ps
// Function
// - Execution time is counted in states of exactly two system clocks.
// - On-chip code is fetched sixteen bits per access, never limiting speed.
// - External code bytes are queued ahead of execution using idle bus time.
// - External fetch costs one state per byte paged, else two plus waits.
// - Effective time is the larger of execution states and fetch limit.
// - Short direct address below 80h is RAM, otherwise special function register.
// - Legacy bits 00h-7Fh map to RAM 20h-2Fh, others to xxh0/xxh8 SFRs.
// - Relative target is next instruction plus signed 8-bit offset.
// - 11-bit stays in 2K block, 16-bit in 64K region, 24-bit anywhere.
// - 32-bit immediate upper word is zeros or ones by encoded form.
// - Short immediate encodes only 1, 2 or 4.
// - Byte registers index 0-15, word registers even 0-30.
// - Dword registers accept 0,4..28, 56 and 60 only.
// - Byte register add/sub: 3 bytes 2 states binary, 2 bytes 1 source.
// - Indirect byte to accumulator: 1 byte 2 states binary, 2 bytes 3 source.
// - Dword register add/sub: 3 bytes 5 states binary, 2 bytes 4 source.
// - Word register 16-bit immediate: 5 bytes 4 states binary, 4/3 source.
// - Carry forms include carry flag; register form 1/1 binary, 2/2 source.
// - Byte direct add/sub adds one state for port, two for peripheral SFR.
// - External byte access by add/sub adds wait states plus two.
// - External word access by add/sub adds twice wait states plus four.
// - Direct increment/decrement adds two states for port, three for peripheral.
// - Dword short increment 3/4 binary, 2/3 source; decrement one more.
// - Opcode map is caught at reset: clear binary, set source mode.
module itd_core (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic src_mode_pin_in,
	input wire logic page_mode_pin_in,
	input wire logic code_ext_pin_in,
	input wire logic [2:0] wait_states_pin_in,
	input wire logic req_valid_in,
	input wire itd_pkg::itd_req_s req_in,
	output logic req_ready_out,
	output logic resp_valid_out,
	output itd_pkg::itd_resp_s resp_out,
	output logic done_out,
	output logic src_mode_out,
	output logic [3:0] queue_level_out
);

	logic [1:0] src_sync_q, page_sync_q, ext_sync_q;
	logic [2:0] ws_sync0_q, ws_sync1_q;
	logic [1:0] strap_cnt_q;
	logic src_mode_q, strap_done_q;
	logic ready_q, valid_q, done_q, busy_q;
	logic [6:0] cyc_cnt_q;
	logic [6:0] fill_cnt_q;
	logic [3:0] queue_q;
	itd_pkg::itd_resp_s resp_q, resp_d;
	logic accept;
	logic [2:0] ws_eff;
	logic [2:0] per_byte;
	logic [5:0] pen;
	logic [8:0] alu_sum;
	logic [2:0] from_q;
	itd_pkg::itd_time_s tab;
	itd_pkg::itd_cost_s cost;

	assign accept = req_valid_in && ready_q;
	assign ws_eff = (ws_sync1_q > itd_pkg::WAIT_MAX) ? itd_pkg::WAIT_MAX : ws_sync1_q;
	assign per_byte = page_sync_q[1] ? itd_pkg::PAGE_STATES_PER_BYTE :
		itd_pkg::NONPAGE_BASE_STATES + ws_eff;

	// Configuration pins are static but still come from outside this clock.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			src_sync_q <= 2'h0;
			page_sync_q <= 2'h0;
			ext_sync_q <= 2'h0;
			ws_sync0_q <= 3'h0;
			ws_sync1_q <= 3'h0;
		end else begin
			src_sync_q <= {src_sync_q[0], src_mode_pin_in};
			page_sync_q <= {page_sync_q[0], page_mode_pin_in};
			ext_sync_q <= {ext_sync_q[0], code_ext_pin_in};
			ws_sync0_q <= wait_states_pin_in;
			ws_sync1_q <= ws_sync0_q;
		end
	end

	// The opcode map is frozen once the synchroniser has filled after release.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			strap_cnt_q <= 2'h0;
			src_mode_q <= 1'b0;
			strap_done_q <= 1'b0;
		end else if (strap_cnt_q != itd_pkg::STRAP_SETTLE) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
		end else if (!strap_done_q) begin
			// The second stage holds the pin only once the settle count is reached.
			strap_done_q <= 1'b1;
			src_mode_q <= src_sync_q[1];
		end
	end

	always_comb begin
		tab = itd_pkg::TIME_TAB[req_in.op];
		cost = src_mode_q ? tab.src : tab.bin;
		pen = 6'h00;
		unique case (req_in.op)
			itd_pkg::OP_A_SHORT_DIRECT_OPERAND, itd_pkg::OP_R_SHORT_DIRECT_OPERAND: begin
				if (req_in.space == itd_pkg::SP_PORT) pen = itd_pkg::PEN_DIR_PORT;
				if (req_in.space == itd_pkg::SP_PERIPH) pen = itd_pkg::PEN_DIR_PERIPH;
			end
			itd_pkg::OP_INC_SHORT_DIRECT_OPERAND: begin
				if (req_in.space == itd_pkg::SP_PORT) pen = itd_pkg::PEN_INC_PORT;
				if (req_in.space == itd_pkg::SP_PERIPH) pen = itd_pkg::PEN_INC_PERIPH;
			end
			itd_pkg::OP_R_DIR16, itd_pkg::OP_R_IND_W, itd_pkg::OP_R_IND_D: begin
				if (req_in.space == itd_pkg::SP_EXT) pen = {3'h0, ws_eff} + 6'h02;
			end
			itd_pkg::OP_W_DIR16: begin
				if (req_in.space == itd_pkg::SP_EXT) pen = {2'h0, ws_eff, 1'b0} + 6'h04;
			end
			default: pen = 6'h00;
		endcase

		resp_d = '0;
		resp_d.bytes = cost.bytes;
		resp_d.exec_states = {2'h0, cost.states} + pen;
		// Queued bytes cover the head of the instruction; only the rest costs fetch time.
		from_q = (queue_q[2:0] >= cost.bytes || queue_q[3]) ? cost.bytes : queue_q[2:0];
		resp_d.fetch_bytes = ext_sync_q[1] ? cost.bytes - from_q : 3'h0;
		if (ext_sync_q[1]) begin
			resp_d.fetch_states = {3'h0, resp_d.fetch_bytes} * {3'h0, per_byte};
		end else begin
			resp_d.fetch_states = {4'h0, 2'(({1'b0, cost.bytes} + 4'h1) >> 1)};
		end
		resp_d.eff_states = (resp_d.fetch_states > resp_d.exec_states) ?
			resp_d.fetch_states : resp_d.exec_states;
		resp_d.dir_is_sfr = req_in.dir_addr >= itd_pkg::SFR_BASE;
		resp_d.opnd_width = req_in.width;
		resp_d.bit_pos = req_in.bit_num[2:0];
		resp_d.bit_byte = req_in.bit_num[7] ? {req_in.bit_num[7:3], 3'h0} :
			itd_pkg::BIT_RAM_BASE + {4'h0, req_in.bit_num[6:3]};
		unique case (req_in.tgt_kind)
			itd_pkg::TG_REL: resp_d.target = req_in.next_pc +
				{{16{req_in.tgt[7]}}, req_in.tgt[7:0]};
			itd_pkg::TG_A11: resp_d.target = {req_in.next_pc[23:11], req_in.tgt[10:0]};
			itd_pkg::TG_A16: resp_d.target = {req_in.next_pc[23:16], req_in.tgt[15:0]};
			itd_pkg::TG_A24: resp_d.target = req_in.tgt;
		endcase
		resp_d.imm32 = {{16{req_in.imm_ones}}, req_in.imm16};
		unique case (req_in.short_code)
			2'h0: resp_d.short_val = itd_pkg::SHORT_ONE;
			2'h1: resp_d.short_val = itd_pkg::SHORT_TWO;
			2'h2: resp_d.short_val = itd_pkg::SHORT_FOUR;
			default: resp_d.short_val = 3'h0;
		endcase
		unique case (req_in.width)
			itd_pkg::W_BYTE: resp_d.operand_ok = req_in.reg_idx <= itd_pkg::BYTE_REG_MAX;
			itd_pkg::W_WORD: resp_d.operand_ok = !req_in.reg_idx[0] &&
				req_in.reg_idx <= itd_pkg::WORD_REG_MAX;
			itd_pkg::W_DWORD: resp_d.operand_ok = (req_in.reg_idx[1:0] == 2'h0) &&
				(req_in.reg_idx <= itd_pkg::DWORD_REG_MAX ||
				req_in.reg_idx == itd_pkg::DWORD_REG_HI0 ||
				req_in.reg_idx == itd_pkg::DWORD_REG_HI1);
			default: resp_d.operand_ok = 1'b0;
		endcase
		if (req_in.op inside {itd_pkg::OP_INC_R_SHORT, itd_pkg::OP_INC_W_SHORT,
			itd_pkg::OP_INC_D_SHORT, itd_pkg::OP_DEC_D_SHORT} && req_in.short_code == 2'h3) begin
			resp_d.operand_ok = 1'b0;
		end
		alu_sum = req_in.sub ?
			{1'b0, req_in.acc} - {1'b0, req_in.src} - {8'h00, req_in.use_carry & req_in.carry_flag} :
			{1'b0, req_in.acc} + {1'b0, req_in.src} + {8'h00, req_in.use_carry & req_in.carry_flag};
		resp_d.alu_res = alu_sum[7:0];
		resp_d.carry_out = alu_sum[8];
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			valid_q <= 1'b0;
			resp_q <= '0;
		end else begin
			valid_q <= accept;
			if (accept) begin
				resp_q <= resp_d;
			end
		end
	end

	// Next request is held off until the instruction's effective time has elapsed.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			busy_q <= 1'b0;
			ready_q <= 1'b0;
			done_q <= 1'b0;
			cyc_cnt_q <= 7'h00;
		end else begin
			done_q <= 1'b0;
			if (accept) begin
				busy_q <= 1'b1;
				ready_q <= 1'b0;
				// The take edge is the first clock, so the next take lands 2*eff after it.
				cyc_cnt_q <= {resp_d.eff_states, 1'b0} - 7'h2;
			end else if (busy_q) begin
				if (cyc_cnt_q == 7'h00) begin
					busy_q <= 1'b0;
					ready_q <= 1'b1;
					done_q <= 1'b1;
				end else begin
					cyc_cnt_q <= cyc_cnt_q - 7'h1;
				end
			end else begin
				ready_q <= strap_cnt_q == itd_pkg::STRAP_SETTLE;
			end
		end
	end

	// Idle external bus time while executing tops up the prefetch queue.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			queue_q <= 4'h0;
			fill_cnt_q <= 7'h00;
		end else if (!ext_sync_q[1]) begin
			queue_q <= 4'h0;
			fill_cnt_q <= 7'h00;
		end else if (accept) begin
			queue_q <= queue_q - {1'b0, from_q};
			fill_cnt_q <= 7'h00;
		end else if (busy_q && queue_q < itd_pkg::PFQ_DEPTH) begin
			if (fill_cnt_q == 7'({per_byte, 1'b0}) - 7'h1) begin
				queue_q <= queue_q + 4'h1;
				fill_cnt_q <= 7'h00;
			end else begin
				fill_cnt_q <= fill_cnt_q + 7'h1;
			end
		end
	end

	assign req_ready_out = ready_q;
	assign resp_valid_out = valid_q;
	assign resp_out = resp_q;
	assign done_out = done_q;
	assign src_mode_out = src_mode_q;
	assign queue_level_out = queue_q;

	logic [7:0] elapsed_q;
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			elapsed_q <= 8'h00;
		end else begin
			elapsed_q <= accept ? 8'h01 : elapsed_q + 8'h01;
		end
	end

	sequence s_accept;
		req_valid_in && req_ready_out;
	endsequence

	sequence s_answer;
		##1 resp_valid_out;
	endsequence

	property p_state_len;
		@(posedge core_clk_in) disable iff (rst_in)
		done_out |-> elapsed_q == {1'b0, resp_out.eff_states, 1'b0};
	endproperty
	a_state_len: assert property (p_state_len) else $error("state length wrong");

	property p_onchip;
		@(posedge core_clk_in) disable iff (rst_in)
		resp_valid_out && !ext_sync_q[1] |-> resp_out.eff_states == resp_out.exec_states;
	endproperty
	a_onchip: assert property (p_onchip) else $error("on-chip fetch limited");

	property p_queue;
		@(posedge core_clk_in) disable iff (rst_in)
		(queue_q <= itd_pkg::PFQ_DEPTH) and (!ext_sync_q[1] |=> queue_q == 4'h0);
	endproperty
	a_queue: assert property (p_queue) else $error("prefetch queue out of range");

	property p_fetch;
		@(posedge core_clk_in) disable iff (rst_in)
		s_accept and ext_sync_q[1] |=> resp_out.fetch_states == {3'h0, resp_out.fetch_bytes} *
			(page_sync_q[1] ? 6'h01 : 6'h02 + {3'h0, $past(ws_eff)});
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch limit wrong");

	property p_eff;
		@(posedge core_clk_in) disable iff (rst_in)
		resp_valid_out |-> resp_out.eff_states >= resp_out.exec_states &&
			resp_out.eff_states >= resp_out.fetch_states;
	endproperty
	a_eff: assert property (p_eff) else $error("effective time not the maximum");

	property p_dir;
		@(posedge core_clk_in) disable iff (rst_in)
		s_accept |-> s_answer ##0 resp_out.dir_is_sfr == $past(req_in.dir_addr[7]);
	endproperty
	a_dir: assert property (p_dir) else $error("direct space decode wrong");

	property p_bit;
		@(posedge core_clk_in) disable iff (rst_in)
		s_accept and !req_in.bit_num[7] |=> resp_out.bit_byte[7:4] == 4'h2;
	endproperty
	a_bit: assert property (p_bit) else $error("legacy bit byte outside 20h-2Fh");

	property p_imm;
		@(posedge core_clk_in) disable iff (rst_in)
		s_accept |=> resp_out.imm32[31:16] == {16{$past(req_in.imm_ones)}};
	endproperty
	a_imm: assert property (p_imm) else $error("immediate fill wrong");

	property p_rr_b;
		@(posedge core_clk_in) disable iff (rst_in)
		s_accept and req_in.op == itd_pkg::OP_RR_B and src_mode_out |=>
			resp_out.bytes == 3'h2 && resp_out.exec_states == 6'h01;
	endproperty
	a_rr_b: assert property (p_rr_b) else $error("byte register timing wrong");

	property p_ext_word;
		@(posedge core_clk_in) disable iff (rst_in)
		s_accept and req_in.op == itd_pkg::OP_W_DIR16 and req_in.space == itd_pkg::SP_EXT
			and !src_mode_out |=> resp_out.exec_states == 6'h08 + {2'h0, $past(ws_eff), 1'b0};
	endproperty
	a_ext_word: assert property (p_ext_word) else $error("external word penalty wrong");

	property p_mode;
		@(posedge core_clk_in) disable iff (rst_in)
		req_ready_out |=> $stable(src_mode_out);
	endproperty
	a_mode: assert property (p_mode) else $error("opcode map changed after reset");

endmodule

// ### design/itd_pkg.sv
package itd_pkg;

	// One execution state spans two system clocks.
	localparam logic [1:0] CYC_PER_STATE = 2'h2;
	localparam logic [2:0] WAIT_MAX = 3'h4;
	localparam logic [2:0] PAGE_STATES_PER_BYTE = 3'h1;
	localparam logic [2:0] NONPAGE_BASE_STATES = 3'h2;
	localparam logic [3:0] PFQ_DEPTH = 4'h4;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	localparam logic [5:0] PEN_DIR_PORT = 6'h01;
	localparam logic [5:0] PEN_DIR_PERIPH = 6'h02;
	localparam logic [5:0] PEN_INC_PORT = 6'h02;
	localparam logic [5:0] PEN_INC_PERIPH = 6'h03;
	localparam logic [7:0] SFR_BASE = 8'h80;
	localparam logic [7:0] BIT_RAM_BASE = 8'h20;
	localparam logic [5:0] BYTE_REG_MAX = 6'h0F;
	localparam logic [5:0] WORD_REG_MAX = 6'h1E;
	localparam logic [5:0] DWORD_REG_MAX = 6'h1C;
	localparam logic [5:0] DWORD_REG_HI0 = 6'h38;
	localparam logic [5:0] DWORD_REG_HI1 = 6'h3C;
	localparam logic [2:0] SHORT_ONE = 3'h1;
	localparam logic [2:0] SHORT_TWO = 3'h2;
	localparam logic [2:0] SHORT_FOUR = 3'h4;

	typedef enum logic [4:0] {
		OP_A_RN, OP_A_SHORT_DIRECT_OPERAND, OP_A_IND, OP_A_IMM, OP_RR_B, OP_RR_W, OP_RR_D, OP_R_IMM8,
		OP_W_IMM16, OP_D_IMM16, OP_R_SHORT_DIRECT_OPERAND, OP_W_SHORT_DIRECT_OPERAND, OP_R_DIR16, OP_W_DIR16, OP_R_IND_W,
		OP_R_IND_D, OP_INC_A, OP_INC_RN, OP_INC_SHORT_DIRECT_OPERAND, OP_INC_IND, OP_INC_R_SHORT,
		OP_INC_W_SHORT, OP_INC_D_SHORT, OP_DEC_D_SHORT, OP_INC_DPTR
	} itd_op_e;
	localparam int unsigned OP_NUM = 25;

	typedef enum logic [1:0] {SP_RAM, SP_PORT, SP_PERIPH, SP_EXT} itd_space_e;
	typedef enum logic [1:0] {TG_REL, TG_A11, TG_A16, TG_A24} itd_tgt_e;
	typedef enum logic [1:0] {W_BYTE, W_WORD, W_DWORD} itd_width_e;

	typedef struct packed {
		logic [2:0] bytes;
		logic [3:0] states;
	} itd_cost_s;

	typedef struct packed {
		itd_cost_s bin;
		itd_cost_s src;
	} itd_time_s;

	localparam itd_time_s TIME_TAB [OP_NUM] = '{
		'{'{3'h1, 4'h1}, '{3'h2, 4'h2}}, '{'{3'h2, 4'h1}, '{3'h2, 4'h1}},
		'{'{3'h1, 4'h2}, '{3'h2, 4'h3}}, '{'{3'h2, 4'h1}, '{3'h2, 4'h1}},
		'{'{3'h3, 4'h2}, '{3'h2, 4'h1}}, '{'{3'h3, 4'h3}, '{3'h2, 4'h2}},
		'{'{3'h3, 4'h5}, '{3'h2, 4'h4}}, '{'{3'h4, 4'h3}, '{3'h3, 4'h2}},
		'{'{3'h5, 4'h4}, '{3'h4, 4'h3}}, '{'{3'h5, 4'h6}, '{3'h4, 4'h5}},
		'{'{3'h4, 4'h3}, '{3'h3, 4'h2}}, '{'{3'h4, 4'h4}, '{3'h3, 4'h3}},
		'{'{3'h5, 4'h3}, '{3'h4, 4'h2}}, '{'{3'h5, 4'h4}, '{3'h4, 4'h3}},
		'{'{3'h4, 4'h3}, '{3'h3, 4'h2}}, '{'{3'h4, 4'h4}, '{3'h3, 4'h3}},
		'{'{3'h1, 4'h1}, '{3'h1, 4'h1}}, '{'{3'h1, 4'h1}, '{3'h2, 4'h2}},
		'{'{3'h2, 4'h2}, '{3'h2, 4'h2}}, '{'{3'h1, 4'h3}, '{3'h2, 4'h4}},
		'{'{3'h3, 4'h2}, '{3'h2, 4'h1}}, '{'{3'h3, 4'h2}, '{3'h2, 4'h1}},
		'{'{3'h3, 4'h4}, '{3'h2, 4'h3}}, '{'{3'h3, 4'h5}, '{3'h2, 4'h4}},
		'{'{3'h1, 4'h1}, '{3'h1, 4'h1}}
	};

	typedef struct packed {
		itd_op_e op;
		logic sub;
		logic use_carry;
		itd_space_e space;
		itd_width_e width;
		logic [7:0] dir_addr;
		logic [7:0] bit_num;
		logic [5:0] reg_idx;
		logic [1:0] short_code;
		logic imm_ones;
		logic [15:0] imm16;
		itd_tgt_e tgt_kind;
		logic [23:0] tgt;
		logic [23:0] next_pc;
		logic [7:0] acc;
		logic [7:0] src;
		logic carry_flag;
	} itd_req_s;

	typedef struct packed {
		logic [2:0] bytes;
		logic [5:0] exec_states;
		logic [2:0] fetch_bytes;
		logic [5:0] fetch_states;
		logic [5:0] eff_states;
		logic dir_is_sfr;
		itd_width_e opnd_width;
		logic [7:0] bit_byte;
		logic [2:0] bit_pos;
		logic [23:0] target;
		logic [31:0] imm32;
		logic [2:0] short_val;
		logic operand_ok;
		logic [7:0] alu_res;
		logic carry_out;
	} itd_resp_s;

endpackage

// ### sim/itd_cfg_src.sv
`timescale 1ns/1ps
// Memory-side configuration source: presents the strap, page mode, code location and
// wait-state count to the core as the external memory system would at its pins.
module itd_cfg_src (
	input wire logic core_clk_in,
	input wire logic [5:0] cfg_in,
	output logic src_mode_pin_out,
	output logic page_mode_pin_out,
	output logic code_ext_pin_out,
	output logic [2:0] wait_states_pin_out
);
	// Pins move only on a clock edge, so the core's synchronisers see clean steps.
	always_ff @(posedge core_clk_in) begin
		src_mode_pin_out <= cfg_in[0];
		page_mode_pin_out <= cfg_in[1];
		code_ext_pin_out <= cfg_in[2];
		wait_states_pin_out <= cfg_in[5:3];
	end
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam int BB[25] = '{1, 2, 1, 2, 3, 3, 3, 4, 5, 5, 4, 4, 5, 5, 4, 4, 1, 1, 2, 1, 3, 3, 3, 3, 1};
	localparam int BS[25] = '{1, 1, 2, 1, 2, 3, 5, 3, 4, 6, 3, 4, 3, 4, 3, 4, 1, 1, 2, 3, 2, 2, 4, 5, 1};
	localparam int SB[25] = '{2, 2, 2, 2, 2, 2, 2, 3, 4, 4, 3, 3, 4, 4, 3, 3, 1, 2, 2, 2, 2, 2, 2, 2, 1};
	localparam int SS[25] = '{2, 1, 3, 1, 1, 2, 4, 2, 3, 5, 2, 3, 2, 3, 2, 3, 1, 2, 2, 4, 1, 1, 3, 4, 1};
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic req_valid_in = 1'b0;
	itd_pkg::itd_req_s req_in = '0;
	itd_pkg::itd_req_s rq;
	logic [5:0] cfg = 6'h00;
	logic src_pin, page_pin, ext_pin;
	logic [2:0] ws_pin;
	logic req_ready_out, resp_valid_out, done_out, src_mode_out;
	logic [3:0] queue_level_out;
	itd_pkg::itd_resp_s resp_out;
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;
	int mode_m = 0;

	itd_cfg_src i_cfg (.core_clk_in(core_clk_in), .cfg_in(cfg), .src_mode_pin_out(src_pin),
		.page_mode_pin_out(page_pin), .code_ext_pin_out(ext_pin), .wait_states_pin_out(ws_pin));

	itd_core i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .src_mode_pin_in(src_pin),
		.page_mode_pin_in(page_pin), .code_ext_pin_in(ext_pin), .wait_states_pin_in(ws_pin),
		.req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
		.resp_valid_out(resp_valid_out), .resp_out(resp_out), .done_out(done_out),
		.src_mode_out(src_mode_out), .queue_level_out(queue_level_out));

	initial begin
		forever #2.5 core_clk_in = ~core_clk_in;
	end

	task automatic close_out();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// The ceiling sits well above the longest planned sequence.
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic itd_pkg::itd_req_s mk(input int op);
		itd_pkg::itd_req_s r;
		logic [127:0] w;
		w = {$urandom, $urandom, $urandom, $urandom};
		r = w[$bits(itd_pkg::itd_req_s)-1:0];
		r.op = itd_pkg::itd_op_e'(op);
		r.width = itd_pkg::itd_width_e'($urandom_range(2, 0));
		return r;
	endfunction

	task automatic do_reset(input logic strap);
		@(posedge core_clk_in);
		#1 rst_in = 1'b1;
		cfg[0] = strap;
		repeat (6) @(posedge core_clk_in);
		chk({req_ready_out, resp_valid_out, done_out}, 0);
		#1 rst_in = 1'b0;
		mode_m = int'(strap);
	endtask

	// External code needs an empty prefetch queue, so code is dropped on-chip first.
	task automatic set_ext(input int page, input int ws);
		@(posedge core_clk_in);
		#1 cfg = {3'(ws), 1'b0, 1'(page), cfg[0]};
		repeat (5) @(posedge core_clk_in);
		#1 cfg[2] = 1'b1;
		repeat (5) @(posedge core_clk_in);
		#1;
	endtask

	task automatic txn(input itd_pkg::itd_req_s r);
		int b, st, pen, n, fch, eff, cnt, ok, sv, cin, done_seen;
		logic [23:0] tg;
		logic [8:0] al;
		n = (cfg[5:3] > 4) ? 4 : int'(cfg[5:3]);
		b = mode_m ? SB[int'(r.op)] : BB[int'(r.op)];
		st = mode_m ? SS[int'(r.op)] : BS[int'(r.op)];
		pen = 0;
		if (r.op == itd_pkg::OP_A_SHORT_DIRECT_OPERAND || r.op == itd_pkg::OP_R_SHORT_DIRECT_OPERAND) begin
			pen = (r.space == itd_pkg::SP_PORT) ? 1 : (r.space == itd_pkg::SP_PERIPH) ? 2 : 0;
		end
		if (r.op == itd_pkg::OP_INC_SHORT_DIRECT_OPERAND) begin
			pen = (r.space == itd_pkg::SP_PORT) ? 2 : (r.space == itd_pkg::SP_PERIPH) ? 3 : 0;
		end
		if (r.space == itd_pkg::SP_EXT && (r.op == itd_pkg::OP_R_DIR16
			|| r.op == itd_pkg::OP_R_IND_W || r.op == itd_pkg::OP_R_IND_D)) begin
			pen = n + 2;
		end
		if (r.space == itd_pkg::SP_EXT && r.op == itd_pkg::OP_W_DIR16) begin
			pen = 2 * (n + 2);
		end
		fch = cfg[2] ? b * (cfg[1] ? 1 : 2 + n) : (b + 1) / 2;
		eff = (st + pen > fch) ? st + pen : fch;
		case (r.width)
			itd_pkg::W_BYTE: ok = (r.reg_idx <= 15);
			itd_pkg::W_WORD: ok = (r.reg_idx[0] == 1'b0 && r.reg_idx <= 30);
			default: ok = ((r.reg_idx[1:0] == 2'h0 && r.reg_idx <= 28) || r.reg_idx == 56
				|| r.reg_idx == 60);
		endcase
		sv = (r.short_code == 2'h3) ? 0 : 1 << r.short_code;
		if (r.op inside {itd_pkg::OP_INC_R_SHORT, itd_pkg::OP_INC_W_SHORT,
			itd_pkg::OP_INC_D_SHORT, itd_pkg::OP_DEC_D_SHORT} && sv == 0) begin
			ok = 0;
		end
		case (r.tgt_kind)
			itd_pkg::TG_REL: tg = r.next_pc + {{16{r.tgt[7]}}, r.tgt[7:0]};
			itd_pkg::TG_A11: tg = {r.next_pc[23:11], r.tgt[10:0]};
			itd_pkg::TG_A16: tg = {r.next_pc[23:16], r.tgt[15:0]};
			default: tg = r.tgt;
		endcase
		cin = int'(r.use_carry & r.carry_flag);
		al = r.sub ? {1'b0, r.acc} - {1'b0, r.src} - 9'(cin) : {1'b0, r.acc} + r.src + 9'(cin);
		req_valid_in = 1'b1;
		req_in = r;
		do @(negedge core_clk_in); while (req_ready_out !== 1'b1);
		@(posedge core_clk_in);
		// Keep a junk request up while busy: it must be ignored.
		#1 req_in = mk(int'($urandom_range(24, 0)));
		cnt = 0;
		done_seen = 0;
		while (!done_seen && cnt < 200) begin
			if (cnt > 0) begin
				@(posedge core_clk_in);
				#1;
			end
			cnt++;
			chk(resp_valid_out, cnt == 1);
			chk(queue_level_out <= 4 && (cfg[2] || queue_level_out == 0), 1);
			if (cnt == 1) begin
				chk(resp_out.bytes, b);
				chk(resp_out.exec_states, st + pen);
				chk(resp_out.fetch_states, fch);
				chk(resp_out.eff_states, eff);
				chk(resp_out.dir_is_sfr, r.dir_addr >= 8'h80);
				chk(resp_out.bit_byte, r.bit_num[7] ? {r.bit_num[7:3], 3'h0}
					: 8'h20 + r.bit_num[6:3]);
				chk(resp_out.bit_pos, r.bit_num[2:0]);
				chk(resp_out.target, tg);
				chk(resp_out.imm32, {{16{r.imm_ones}}, r.imm16});
				chk(resp_out.short_val, sv);
				chk(resp_out.operand_ok, ok);
				chk({resp_out.carry_out, resp_out.alu_res}, al);
			end
			if (done_out === 1'b1) begin
				done_seen = 1;
				// Ready rises with done, so the junk request must go before the next edge.
				req_valid_in = 1'b0;
			end else begin
				chk(req_ready_out, 0);
			end
		end
		chk(cnt, 2 * eff);
		@(posedge core_clk_in);
		#1 req_valid_in = 1'b0;
	endtask

	initial begin
		void'($urandom(32'h6c81));
		for (int m = 0; m < 2; m++) begin
			do_reset(m[0]);
			for (int op = 0; op < 25; op++) begin
				txn(mk(op));
			end
			chk(src_mode_out, m);
			@(posedge core_clk_in);
			#1 cfg[0] = ~cfg[0];
			repeat (6) @(posedge core_clk_in);
			chk(src_mode_out, m);
			for (int w = 0; w < 3; w++) begin
				for (int i = 0; i < 64; i++) begin
					rq = mk(int'(itd_pkg::OP_INC_D_SHORT));
					rq.width = itd_pkg::itd_width_e'(w);
					rq.reg_idx = 6'(i);
					rq.short_code = 2'(i);
					txn(rq);
				end
			end
			for (int pg = 0; pg < 2; pg++) begin
				for (int ws = 0; ws < 6; ws++) begin
					set_ext(pg, ws);
					txn(mk(int'($urandom_range(24, 0))));
				end
			end
			for (int k = 0; k < 30; k++) begin
				set_ext(int'($urandom_range(1, 0)), int'($urandom_range(5, 0)));
				txn(mk(int'($urandom_range(24, 0))));
			end
			@(posedge core_clk_in);
			#1 cfg[2] = 1'b0;
		end
		close_out();
	end
endmodule
